// *** design/frb_fuse_cmd.sv ***
/*
 * Command engine for memory read, single status-fuse burn, transport-key
 * generation and bulk fuse burn.
 * Assumes commands arrive framed and CRC-checked from the link logic, a
 * SHA-256 core hashes one block on request, and the fuse array burns one
 * fuse per pulse; the whole block is reset by nrst on each wake.
 */
`timescale 1ns/1ps
`default_nettype none
module frb_fuse_cmd #(
    parameter int SHORT_CYC = frb_pkg::SHORT_BURN_CYC,
    parameter int LONG_CYC = frb_pkg::LONG_BURN_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic watchdog_expired,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire frb_pkg::frb_cmd_s cmd,
    output logic rsp_valid,
    output frb_pkg::frb_rsp_s rsp,
    input wire logic rsp_ack,
    input wire logic [frb_pkg::FUSE_COUNT-1:0] fuse_state,
    output logic [31:0] rom_addr,
    input wire logic [31:0] rom_data,
    input wire logic [255:0] personalization_key_slot,
    output logic [15:0] key_index,
    output logic sha_start,
    output logic [511:0] sha_block,
    input wire logic sha_done,
    input wire logic [255:0] sha_digest,
    output logic fuse_burn,
    output logic [6:0] fuse_burn_index,
    output logic digest_valid
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic lock_burned(input logic [frb_pkg::FUSE_COUNT-1:0] f);
        // burned fuses read zero
        lock_burned = !f[frb_pkg::LOCK_FUSE];
    endfunction

    function automatic logic [6:0] first_one(input logic [frb_pkg::MAP_BITS-1:0] m);
        first_one = 7'h00;
        for (int i = frb_pkg::MAP_BITS - 1; i >= 0; i--) begin
            if (m[i]) begin
                first_one = 7'(i);
            end
        end
    endfunction

    frb_pkg::frb_state_e state_q;
    logic [frb_pkg::MAP_BITS-1:0] map_q;
    logic [frb_pkg::BURN_CNT_W-1:0] burn_cnt_q;
    logic long_q;
    logic [255:0] digest_q;
    logic [7:0] result_q;
    logic [6:0] idx_q;
    logic [127:0] seed_q;

    wire [7:0] op = cmd.opcode;
    wire [7:0] p1 = cmd.param1;
    wire [15:0] p2 = cmd.param2;
    wire take = cmd_valid && cmd_ready;
    wire [6:0] fuse_idx = p1[6:0];
    wire single_idx_ok = (p1 >= 8'(frb_pkg::STATUS_FIRST))
        && (p1 <= 8'(frb_pkg::STATUS_LAST));
    wire dur_ok = (p2 == frb_pkg::BURN_SHORT) || (p2 == frb_pkg::BURN_LONG);
    wire [31:0] fuse_word = fuse_state[{p2[1:0], 5'h00} +: 32];
    wire [frb_pkg::MAP_BITS-1:0] clear_map = (p1 == 8'h01)
        ? (cmd.data[frb_pkg::MAP_BITS-1:0] ^ digest_q[frb_pkg::MAP_BITS-1:0])
        : cmd.data[frb_pkg::MAP_BITS-1:0];

    assign cmd_ready = (state_q == frb_pkg::FRB_IDLE) && !rsp_valid;
    assign rom_addr = {30'h0000_0000, p2[1:0]};

    // ------------------------------------------------------------
    // command state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= frb_pkg::FRB_IDLE;
            rsp_valid <= 1'b0;
            rsp <= '0;
            map_q <= '0;
            long_q <= 1'b0;
            result_q <= 8'h00;
            idx_q <= 7'h00;
            seed_q <= '0;
            key_index <= 16'h0000;
        end else begin
            if (rsp_valid && rsp_ack) begin
                rsp_valid <= 1'b0;
            end
            case (state_q)
                frb_pkg::FRB_IDLE: begin
                    if (take) begin
                        rsp <= '{len: 3'd1, bytes: {24'h00_0000, frb_pkg::RSP_ERR}};
                        rsp_valid <= 1'b1;
                        case (op)
                            frb_pkg::OP_READ: begin
                                if (p2[15:2] == 14'h0000) begin
                                    if (p1 == frb_pkg::MODE_ROM && !p2[frb_pkg::ADDR_FUSE_BIT]) begin
                                        rsp <= '{len: 3'd4, bytes: rom_data};
                                    end else if (p1 == frb_pkg::MODE_FUSE
                                        && p2[frb_pkg::ADDR_FUSE_BIT]) begin
                                        // addresses 2,3 cover fuses 64..127 only
                                        rsp <= '{len: 3'd4, bytes: fuse_word};
                                    end
                                end
                            end
                            frb_pkg::OP_SINGLE_BURN: begin
                                if (single_idx_ok && dur_ok
                                    && fuse_state[frb_pkg::SINGLE_ENABLE_FUSE]) begin
                                    rsp_valid <= 1'b0;
                                    map_q <= '0;
                                    map_q[fuse_idx] <= 1'b1;
                                    long_q <= (p2 == frb_pkg::BURN_LONG);
                                    state_q <= frb_pkg::FRB_BURN;
                                end
                            end
                            frb_pkg::OP_TRANSPORT_KEY: begin
                                if (p1 == 8'h00 && !lock_burned(fuse_state)) begin
                                    rsp_valid <= 1'b0;
                                    key_index <= p2;
                                    seed_q <= cmd.data;
                                    state_q <= frb_pkg::FRB_HASH;
                                end
                            end
                            frb_pkg::OP_BULK_BURN: begin
                                // encrypted map needs a digest from this wake
                                if (dur_ok && !lock_burned(fuse_state)
                                    && (p1 == 8'h00 || (p1 == 8'h01 && digest_valid))) begin
                                    rsp_valid <= 1'b0;
                                    map_q <= clear_map;
                                    long_q <= (p2 == frb_pkg::BURN_LONG);
                                    state_q <= frb_pkg::FRB_BURN;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                frb_pkg::FRB_HASH: begin
                    if (sha_done) begin
                        state_q <= frb_pkg::FRB_DONE;
                    end
                end
                frb_pkg::FRB_BURN: begin
                    if (map_q == '0) begin
                        state_q <= frb_pkg::FRB_DONE;
                    end else begin
                        idx_q <= first_one(map_q);
                        map_q[first_one(map_q)] <= 1'b0;
                        state_q <= frb_pkg::FRB_WAIT;
                    end
                end
                frb_pkg::FRB_WAIT: begin
                    if (burn_cnt_q == '0) begin
                        state_q <= frb_pkg::FRB_BURN;
                    end
                end
                frb_pkg::FRB_DONE: begin
                    rsp <= '{len: 3'd1, bytes: {24'h00_0000, frb_pkg::RSP_OK}};
                    rsp_valid <= 1'b1;
                    state_q <= frb_pkg::FRB_IDLE;
                end
                default: begin
                    state_q <= frb_pkg::FRB_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // burn timer and fuse strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            burn_cnt_q <= '0;
            fuse_burn <= 1'b0;
            fuse_burn_index <= 7'h00;
        end else begin
            fuse_burn <= 1'b0;
            if (state_q == frb_pkg::FRB_BURN && map_q != '0) begin
                fuse_burn <= 1'b1;
                fuse_burn_index <= first_one(map_q);
                burn_cnt_q <= long_q ? frb_pkg::BURN_CNT_W'(LONG_CYC - 1)
                    : frb_pkg::BURN_CNT_W'(SHORT_CYC - 1);
            end else if (burn_cnt_q != '0) begin
                burn_cnt_q <= burn_cnt_q - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // transport digest
    // ------------------------------------------------------------
    assign sha_block = {personalization_key_slot, 64'hFFFF_FFFF_FFFF_FFFF,
        seed_q[127:1], 1'b1, frb_pkg::MSG_LEN};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sha_start <= 1'b0;
            digest_q <= '0;
            digest_valid <= 1'b0;
        end else begin
            sha_start <= take && op == frb_pkg::OP_TRANSPORT_KEY && p1 == 8'h00
                && !lock_burned(fuse_state);
            if (watchdog_expired) begin
                digest_valid <= 1'b0;
                digest_q <= '0;
            end else if (state_q == frb_pkg::FRB_HASH && sha_done) begin
                digest_q <= sha_digest;
                digest_valid <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** design/frb_pkg.sv ***
/*
 * Package for the fuse read, burn and transport-key command block.
 * Assumes a parsed command arrives as one packet word and that an outside
 * SHA-256 core and fuse array answer over plain handshakes.
 */
package frb_pkg;
    localparam logic [7:0] OP_READ = 8'h02;
    localparam logic [7:0] OP_SINGLE_BURN = 8'h04;
    localparam logic [7:0] OP_BULK_BURN = 8'h10;
    localparam logic [7:0] OP_TRANSPORT_KEY = 8'h20;
    localparam logic [7:0] MODE_ROM = 8'h00;
    localparam logic [7:0] MODE_FUSE = 8'h01;
    localparam logic [7:0] RSP_OK = 8'h00;
    localparam logic [7:0] RSP_ERR = 8'h0F;
    localparam logic [15:0] BURN_SHORT = 16'h0000;
    localparam logic [15:0] BURN_LONG = 16'hFFFF;
    localparam int FUSE_COUNT = 128;
    localparam int MAP_BITS = 88;
    localparam int SECRET_FUSES = 64;
    localparam int STATUS_FIRST = 64;
    localparam int STATUS_LAST = 86;
    localparam int LOCK_FUSE = 87;
    localparam int SINGLE_ENABLE_FUSE = 1;
    localparam int FUSE_SHIFT = 5;
    localparam int ADDR_FUSE_BIT = 1;
    localparam logic [63:0] MSG_LEN = 64'h0000_0000_0000_01BF;
    localparam int CLK_MHZ = 100;
    localparam int SHORT_BURN_US = 250;
    localparam int LONG_BURN_MS = 262;
    // longest times round down
    localparam int SHORT_BURN_CYC = SHORT_BURN_US * CLK_MHZ;
    localparam int LONG_BURN_CYC = LONG_BURN_MS * 1000 * CLK_MHZ;
    localparam int BURN_CNT_W = 25;

    typedef enum logic [2:0] {
        FRB_IDLE = 3'b000,
        FRB_HASH = 3'b001,
        FRB_BURN = 3'b010,
        FRB_WAIT = 3'b011,
        FRB_DONE = 3'b100
    } frb_state_e;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] param1;
        logic [15:0] param2;
        logic [127:0] data;
    } frb_cmd_s;

    typedef struct packed {
        logic [2:0] len;
        logic [31:0] bytes;
    } frb_rsp_s;
endpackage

// *** dv/frb_far_model.sv ***
/* frb_far_model: fuse array, ROM and hash core beside frb_fuse_cmd.
   Driven by the block's ports; fuses start unburned and never reset. */
`timescale 1ns/1ps
`default_nettype none
module frb_far_model (
    input wire logic clk,
    input wire logic fuse_burn,
    input wire logic [6:0] fuse_burn_index,
    input wire logic [31:0] rom_addr,
    input wire logic [15:0] key_index,
    input wire logic sha_start,
    input wire logic [511:0] sha_block,
    output logic [127:0] fuse_state,
    output logic [31:0] rom_data,
    output logic [255:0] personalization_key_slot,
    output logic sha_done,
    output logic [255:0] sha_digest
);
    logic [2:0] sd_q;
    initial begin
        fuse_state = '1;
        sd_q = '0;
        sha_digest = '0;
    end
    always @(posedge clk) begin
        if (fuse_burn) begin
            fuse_state[fuse_burn_index] <= 1'b0;
        end
        sd_q <= {sd_q[1:0], sha_start};
        if (sha_start) begin
            sha_digest <= ~sha_block[511:256];
        end
    end
    assign sha_done = sd_q[2];
    assign rom_data = 32'hA5C3_0000 | rom_addr;
    assign personalization_key_slot = {16{key_index}};
endmodule
`default_nettype wire

// *** dv/frb_fuse_cmd_props.sv ***
/* frb_fuse_cmd_props: port assertions for frb_fuse_cmd.
   Bound into every frb_fuse_cmd; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module frb_fuse_cmd_props #(
    parameter int SHORT_CYC = 4,
    parameter int LONG_CYC = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic watchdog_expired,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire frb_pkg::frb_cmd_s cmd,
    input wire logic rsp_valid,
    input wire frb_pkg::frb_rsp_s rsp,
    input wire logic rsp_ack,
    input wire logic [frb_pkg::FUSE_COUNT-1:0] fuse_state,
    input wire logic sha_start,
    input wire logic [511:0] sha_block,
    input wire logic fuse_burn,
    input wire logic [6:0] fuse_burn_index,
    input wire logic digest_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [31:0] gap_q;
    wire logic take = cmd_valid && cmd_ready;
    wire logic sb = take && cmd.opcode == frb_pkg::OP_SINGLE_BURN;
    wire logic in_rng = cmd.param1 >= 8'h40 && cmd.param1 <= 8'h56;
    wire logic err = rsp_valid && rsp.len == 3'd1 && rsp.bytes[7:0] == frb_pkg::RSP_ERR;
    // cycles since the last burn pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap_q <= 32'(SHORT_CYC);
        end else if (fuse_burn) begin
            gap_q <= 32'h0;
        end else if (gap_q < 32'(LONG_CYC)) begin
            gap_q <= gap_q + 32'h1;
        end
    end
    // ----------------
    // assertions
    // ----------------
    rsp_hold_a: assert property (rsp_valid && !rsp_ack |=> rsp_valid && $stable(rsp))
        else $error("response dropped or changed before ack");
    busy_ready_a: assert property (rsp_valid |-> !cmd_ready)
        else $error("command accepted while a response waits");
    read_len_a: assert property (take && cmd.opcode == 8'h02 && cmd.param2 == 16'h0001
        && cmd.param1 == 8'h00 |=> rsp_valid && rsp.len == 3'd4)
        else $error("rom read did not answer four bytes");
    bad_op_a: assert property (take && !(cmd.opcode inside {8'h02, 8'h04, 8'h10, 8'h20})
        |=> err) else $error("bad opcode not answered with error");
    range_err_a: assert property (sb && !in_rng |=> err && !fuse_burn)
        else $error("out of range fuse index not refused");
    one_fuse_a: assert property (sb && in_rng && cmd.param2 == 16'h0 && fuse_state[1]
        |=> ##1 fuse_burn && fuse_burn_index == $past(cmd.param1[6:0], 2))
        else $error("single burn hit wrong fuse");
    seed_pos_a: assert property (sha_start |-> sha_block[191:65] == $past(cmd.data[127:1]))
        else $error("seed bits misplaced in hash block");
    enable_err_a: assert property (sb && !fuse_state[1] |=> err && !fuse_burn)
        else $error("single burn ran with enable fuse burned");
    lock_err_a: assert property (take && cmd.opcode inside {8'h10, 8'h20} && !fuse_state[87]
        |=> err && !sha_start && !fuse_burn) else $error("lock fuse burned but command ran");
    pad_len_a: assert property (sha_start |-> sha_block[63:0] == frb_pkg::MSG_LEN
        && sha_block[64] && &sha_block[255:192]) else $error("hash block padding wrong");
    dig_clear_a: assert property (watchdog_expired |=> !digest_valid)
        else $error("digest flag survived watchdog");
    burn_gap_a: assert property (fuse_burn |-> gap_q + 32'h1 >= 32'(SHORT_CYC))
        else $error("burn pulses closer than burn time");
    cover property (sb ##2 fuse_burn);
    cover property ($rose(digest_valid));
    cover property (rsp_valid && rsp.len == 3'd4);
endmodule
bind frb_fuse_cmd frb_fuse_cmd_props #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC))
    u_props (.clk(clk), .nrst(nrst), .watchdog_expired(watchdog_expired),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp(rsp), .rsp_ack(rsp_ack), .fuse_state(fuse_state), .sha_start(sha_start),
    .sha_block(sha_block), .fuse_burn(fuse_burn), .fuse_burn_index(fuse_burn_index),
    .digest_valid(digest_valid));
`default_nettype wire

// *** dv/frb_fuse_cmd_tb.sv ***
/* frb_fuse_cmd_tb: directed scenarios for frb_fuse_cmd.
   Uses frb_far_model for fuses, ROM and hash; burn counts shortened. */
`timescale 1ns/1ps
`default_nettype none
module frb_fuse_cmd_tb;
    logic clk, nrst, wdog, cmd_valid, rsp_ack;
    frb_pkg::frb_cmd_s cmd;
    frb_pkg::frb_rsp_s rsp;
    wire logic cmd_ready, rsp_valid, sha_start, sha_done, fuse_burn, digest_valid;
    wire logic [127:0] fuse_state;
    wire logic [31:0] rom_addr, rom_data;
    wire logic [255:0] key, digest;
    wire logic [15:0] key_index;
    wire logic [511:0] sha_block;
    wire logic [6:0] burn_idx;
    logic [127:0] exp_f;
    int failures, comparisons;
    frb_fuse_cmd #(.SHORT_CYC(4), .LONG_CYC(8)) uut (.clk(clk), .nrst(nrst),
        .watchdog_expired(wdog), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ack(rsp_ack), .fuse_state(fuse_state),
        .rom_addr(rom_addr), .rom_data(rom_data), .personalization_key_slot(key),
        .key_index(key_index), .sha_start(sha_start), .sha_block(sha_block),
        .sha_done(sha_done), .sha_digest(digest), .fuse_burn(fuse_burn),
        .fuse_burn_index(burn_idx), .digest_valid(digest_valid));
    frb_far_model far (.clk(clk), .fuse_burn(fuse_burn), .fuse_burn_index(burn_idx),
        .rom_addr(rom_addr), .key_index(key_index), .sha_start(sha_start),
        .sha_block(sha_block), .fuse_state(fuse_state), .rom_data(rom_data),
        .personalization_key_slot(key), .sha_done(sha_done), .sha_digest(digest));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic close_out;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [127:0] e, input logic [127:0] s);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic run(input logic [7:0] op, input logic [7:0] p1, input logic [15:0] p2,
                       input logic [127:0] d, input logic [2:0] l, input logic [31:0] b);
        int n;
        n = 0;
        cmd = '{op, p1, p2, d};
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (cmd_ready !== 1'b1) begin
            failures++;
            close_out();
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 500) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (rsp_valid !== 1'b1) begin
            failures++;
            close_out();
        end
        chk("rsp_len", 128'(l), 128'(rsp.len));
        chk("rsp_bytes", 128'(b), 128'(l == 3'd4 ? rsp.bytes : {24'h0, rsp.bytes[7:0]}));
        chk("fuses", exp_f, fuse_state);
        rsp_ack = 1'b1;
        @(posedge clk);
        #1;
        rsp_ack = 1'b0;
    endtask
    task automatic t_read;
        run(8'h02, 8'h00, 16'h0001, '0, 3'd4, 32'hA5C3_0001);
        run(8'h02, 8'h01, 16'h0003, '0, 3'd4, 32'hFFFF_FFFF);
    endtask
    task automatic t_errs;
        run(8'h77, 8'h00, 16'h0000, '0, 3'd1, 32'h0F);
        run(8'h02, 8'h00, 16'h0004, '0, 3'd1, 32'h0F);
        run(8'h02, 8'h00, 16'h0002, '0, 3'd1, 32'h0F);
        run(8'h02, 8'h01, 16'h0000, '0, 3'd1, 32'h0F);
        run(8'h04, 8'h3F, 16'h0000, '0, 3'd1, 32'h0F);
        run(8'h04, 8'h57, 16'h0000, '0, 3'd1, 32'h0F);
        run(8'h04, 8'h46, 16'h0001, '0, 3'd1, 32'h0F);
        run(8'h20, 8'h01, 16'h0000, '0, 3'd1, 32'h0F);
    endtask
    task automatic t_single;
        exp_f[70] = 1'b0;
        run(8'h04, 8'h46, 16'h0000, '0, 3'd1, 32'h00);
        exp_f[86] = 1'b0;
        run(8'h04, 8'h56, 16'hFFFF, '0, 3'd1, 32'h00);
        run(8'h02, 8'h01, 16'h0002, '0, 3'd4, 32'hFFBF_FFBF);
    endtask
    task automatic t_key;
        run(8'h20, 8'h00, 16'h0000, 128'h1, 3'd1, 32'h00);
        chk("digest_valid", 128'h1, 128'(digest_valid));
        wdog = 1'b1;
        @(posedge clk);
        #1;
        wdog = 1'b0;
        chk("digest_valid", 128'h0, 128'(digest_valid));
        run(8'h10, 8'h01, 16'h0000, 128'h20, 3'd1, 32'h0F);
        run(8'h20, 8'h00, 16'h0000, '0, 3'd1, 32'h00);
        exp_f[5] = 1'b0;
        run(8'h10, 8'h01, 16'h0000, {40'h0, ~88'h20}, 3'd1, 32'h00);
        exp_f[1] = 1'b0;
        exp_f[80] = 1'b0;
        run(8'h10, 8'h00, 16'hFFFF, 128'h1_0000_0000_0000_0000_0002, 3'd1, 32'h00);
        run(8'h04, 8'h46, 16'h0000, '0, 3'd1, 32'h0F);
    endtask
    task automatic t_lock;
        exp_f[87] = 1'b0;
        run(8'h10, 8'h00, 16'h0000, 128'h8_00000_0000_0000_0000_0000, 3'd1, 32'h00);
        run(8'h20, 8'h00, 16'h0000, '0, 3'd1, 32'h0F);
        run(8'h10, 8'h00, 16'h0000, 128'h8, 3'd1, 32'h0F);
    endtask
    initial begin
        failures = 0;
        comparisons = 0;
        nrst = 1'b0;
        wdog = 1'b0;
        cmd_valid = 1'b0;
        rsp_ack = 1'b0;
        cmd = '0;
        exp_f = '1;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_read();
        t_errs();
        t_single();
        t_key();
        t_lock();
        close_out();
    end
endmodule
`default_nettype wire
